// *** lcra_regs.svh ***
/*
 * Constants of the character display RAM-access instruction block: Avalon offsets,
 * field positions, reset values, address limits, memory sizes and busy times.
 * Assumes inclusion by bare name from the core module only; the package does not include it.
 */
`ifndef LCRA_REGS_SVH
`define LCRA_REGS_SVH

// avalon byte offsets
`define LCRA_CFG_OFS 4'h0
`define LCRA_STAT_OFS 4'h4

// configuration register fields
`define LCRA_CFG_INC_BIT 0
`define LCRA_CFG_SCROLL_BIT 1
`define LCRA_CFG_TWO_LINE_BIT 2
`define LCRA_CFG_WIDTH8_BIT 3
`define LCRA_CFG_W 4
`define LCRA_CFG_RESET 4'h9

// status register fields
`define LCRA_STAT_AC_LSB 0
`define LCRA_STAT_BUSY_BIT 7
`define LCRA_STAT_GLYPH_BIT 8
`define LCRA_STAT_SHIFT_LSB 16

// text and glyph memory address limits
`define LCRA_ONE_LINE_LAST 7'h4f
`define LCRA_LINE1_LAST 7'h27
`define LCRA_LINE2_FIRST 7'h40
`define LCRA_LINE2_LAST 7'h67
`define LCRA_GLYPH_LAST 7'h3f

// memory sizes
`define LCRA_TEXT_DEPTH 128
`define LCRA_GLYPH_DEPTH 64

// busy times in microseconds and clock rate in MHz
`define LCRA_INSTR_US 39
`define LCRA_DATA_US 43
`define LCRA_CLK_MHZ 100
`define LCRA_CNT_W 13

`endif

// *** lcra_pkg.sv ***
/*
 * Types shared by the RAM-access instruction block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcra_pkg;

    typedef enum logic [0:0] {
        lcra_idle = 1'b0,
        lcra_busy = 1'b1
    } lcra_state_e;

    typedef enum logic [2:0] {
        lcra_op_none = 3'b000,
        lcra_op_addr_text = 3'b001,
        lcra_op_addr_glyph = 3'b010,
        lcra_op_cursor = 3'b011,
        lcra_op_dshift = 3'b100,
        lcra_op_write = 3'b101,
        lcra_op_read = 3'b110
    } lcra_op_e;

endpackage : lcra_pkg

// *** lcra_sync.sv ***
/*
 * Three-stage input synchroniser with agreement filter, one lane per bit.
 * Assumes inputs come from outside the clk domain; output is a register.
 */
module lcra_sync #(
    parameter int WIDTH = 11
) (
    // clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            logic ff1_reg;
            logic ff2_reg;
            logic ff3_reg;
            logic stable_reg;
            logic stable_next;

            // first stage feeds only the second
            always_comb begin
                stable_next = stable_reg;
                if (ff2_reg == ff3_reg) begin
                    stable_next = ff3_reg;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    ff1_reg <= 1'b0;
                    ff2_reg <= 1'b0;
                    ff3_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end else if (clk_en) begin
                    ff1_reg <= async_in[i];
                    ff2_reg <= ff1_reg;
                    ff3_reg <= ff2_reg;
                    stable_reg <= stable_next;
                end
            end

            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule : lcra_sync

// *** lcra_core.sv ***
/*
 * RAM-access instruction interpreter of a character display controller: parallel
 * host port, shared address counter, busy indicator, text and glyph memories,
 * read prefetch latch, plus an Avalon-MM slave for configuration and status.
 * Assumes the host holds each enable level for at least four clk cycles and that
 * the pin-side bus resolves data_out against data_oe.
 */
`include "lcra_regs.svh"

// Behaviour
// - instruction write with top bit set loads seven bits into counter, selects text memory
// - one-line text addresses run 00h to 4fh contiguously
// - two-line text addresses are 00h-27h and 40h-67h
// - status read returns busy indicator on bit 7, counter below
// - while busy, every instruction except status read is ignored
// - one address counter serves glyph and text memory, set by last instruction
// - data write stores the byte into the memory last selected
// - after data write counter steps by entry direction, display scrolls if enabled and text memory is selected
// - data read drives a byte from the memory last selected
// - first read without preceding address set is invalid, later reads correct
// - cursor shift validates the next text memory read like an address set
// - after data read counter steps by entry direction, display never shifts
// - after a write the new location reads wrong until address set, or cursor shift in text memory
// - entry direction one increments the counter, zero decrements it
// - in 4-bit mode each byte is two transfers on the upper lines
// - counter update after a data access happens once busy clears
module lcra_core #(
    parameter int unsigned CLK_MHZ = `LCRA_CLK_MHZ,
    parameter logic [`LCRA_CNT_W-1:0] INSTR_BUSY_CYCLES = `LCRA_CNT_W'(`LCRA_INSTR_US * CLK_MHZ),
    parameter logic [`LCRA_CNT_W-1:0] DATA_BUSY_CYCLES = `LCRA_CNT_W'(`LCRA_DATA_US * CLK_MHZ)
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // parallel host port
    input wire logic register_select,
    input wire logic read_not_write,
    input wire logic enable,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    logic [10:0] pins_sync;
    logic rs_s;
    logic rw_s;
    logic e_s;
    logic [7:0] din_s;

    lcra_sync #(.WIDTH(11)) u_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in({register_select, read_not_write, enable, data_in}),
        .sync_out(pins_sync)
    );

    assign rs_s = pins_sync[10];
    assign rw_s = pins_sync[9];
    assign e_s = pins_sync[8];
    assign din_s = pins_sync[7:0];

    logic [7:0] text_mem [0:`LCRA_TEXT_DEPTH-1];
    logic [7:0] glyph_mem [0:`LCRA_GLYPH_DEPTH-1];

    lcra_pkg::lcra_state_e state_reg, state_next;
    lcra_pkg::lcra_op_e op_reg, op_next;
    logic [`LCRA_CNT_W-1:0] count_reg, count_next;
    logic [6:0] ac_reg, ac_next;
    logic glyph_sel_reg, glyph_sel_next;
    logic [7:0] latch_reg, latch_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [6:0] arg_reg, arg_next;
    logic dir_reg, dir_next;
    logic [3:0] nib_hi_reg, nib_hi_next;
    logic nib_phase_reg, nib_phase_next;
    logic e_prev_reg;
    logic [7:0] dout_reg, dout_next;
    logic doe_reg, doe_next;
    logic [6:0] shift_reg, shift_next;
    logic [`LCRA_CFG_W-1:0] cfg_reg, cfg_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wait_reg, wait_next;
    logic text_we;
    logic glyph_we;

    logic entry_inc;
    logic auto_scroll;
    logic two_line;
    logic bus_width_select;
    logic busy_indicator;
    assign entry_inc = cfg_reg[`LCRA_CFG_INC_BIT];
    assign auto_scroll = cfg_reg[`LCRA_CFG_SCROLL_BIT];
    assign two_line = cfg_reg[`LCRA_CFG_TWO_LINE_BIT];
    assign bus_width_select = cfg_reg[`LCRA_CFG_WIDTH8_BIT];
    assign busy_indicator = (state_reg == lcra_pkg::lcra_busy);

    // wraps at the ends of the valid address windows
    function automatic logic [6:0] lcra_step(input logic [6:0] a, input logic inc,
                                             input logic glyph, input logic two);
        logic [6:0] r;
        r = inc ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            r = r & `LCRA_GLYPH_LAST;
        end else if (two) begin
            if (inc && a == `LCRA_LINE1_LAST) begin
                r = `LCRA_LINE2_FIRST;
            end else if (inc && a == `LCRA_LINE2_LAST) begin
                r = 7'h00;
            end else if (!inc && a == `LCRA_LINE2_FIRST) begin
                r = `LCRA_LINE1_LAST;
            end else if (!inc && a == 7'h00) begin
                r = `LCRA_LINE2_LAST;
            end
        end else begin
            if (inc && a == `LCRA_ONE_LINE_LAST) begin
                r = 7'h00;
            end else if (!inc && a == 7'h00) begin
                r = `LCRA_ONE_LINE_LAST;
            end
        end
        return r;
    endfunction : lcra_step

    logic step_inc;
    logic [6:0] ac_stepped;
    logic [7:0] rd_stepped;
    logic [7:0] rd_byte;
    logic [7:0] full_byte;
    logic e_rise;
    logic e_fall;
    logic status_rd;
    logic accept;

    always_comb begin
        step_inc = (op_reg == lcra_pkg::lcra_op_cursor) ? dir_reg : entry_inc;
        ac_stepped = lcra_step(ac_reg, step_inc, glyph_sel_reg, two_line);
        rd_stepped = glyph_sel_reg ? glyph_mem[ac_stepped[5:0]] : text_mem[ac_stepped];
        e_rise = e_s && !e_prev_reg;
        e_fall = !e_s && e_prev_reg;
        status_rd = !rs_s && rw_s;
        accept = !busy_indicator || status_rd;
        rd_byte = status_rd ? {busy_indicator, ac_reg} : latch_reg;
        full_byte = bus_width_select ? din_s : {nib_hi_reg, din_s[7:4]};
    end

    // host port and instruction execution
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        count_next = count_reg;
        ac_next = ac_reg;
        glyph_sel_next = glyph_sel_reg;
        latch_next = latch_reg;
        wdata_next = wdata_reg;
        arg_next = arg_reg;
        dir_next = dir_reg;
        nib_hi_next = nib_hi_reg;
        nib_phase_next = nib_phase_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        shift_next = shift_reg;
        text_we = 1'b0;
        glyph_we = 1'b0;

        case (state_reg)
            lcra_pkg::lcra_busy: begin
                if (count_reg != '0) begin
                    count_next = count_reg - `LCRA_CNT_W'(1);
                end else begin
                    state_next = lcra_pkg::lcra_idle;
                    op_next = lcra_pkg::lcra_op_none;
                    case (op_reg)
                        lcra_pkg::lcra_op_addr_text: begin
                            ac_next = arg_reg;
                            glyph_sel_next = 1'b0;
                            latch_next = text_mem[arg_reg];
                        end
                        lcra_pkg::lcra_op_addr_glyph: begin
                            ac_next = arg_reg;
                            glyph_sel_next = 1'b1;
                            latch_next = glyph_mem[arg_reg[5:0]];
                        end
                        lcra_pkg::lcra_op_cursor: begin
                            ac_next = ac_stepped;
                            if (!glyph_sel_reg) begin
                                latch_next = rd_stepped;
                            end
                        end
                        lcra_pkg::lcra_op_dshift: begin
                            shift_next = dir_reg ? shift_reg + 7'h01 : shift_reg - 7'h01;
                        end
                        lcra_pkg::lcra_op_write: begin
                            text_we = !glyph_sel_reg;
                            glyph_we = glyph_sel_reg;
                            ac_next = ac_stepped;
                            // latch keeps old contents on purpose
                            if (auto_scroll && !glyph_sel_reg) begin
                                shift_next = entry_inc ? shift_reg - 7'h01 : shift_reg + 7'h01;
                            end
                        end
                        lcra_pkg::lcra_op_read: begin
                            ac_next = ac_stepped;
                            latch_next = rd_stepped;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
            end
        endcase

        if (e_rise && rw_s && accept) begin
            doe_next = 1'b1;
            if (bus_width_select) begin
                dout_next = rd_byte;
            end else if (nib_phase_reg) begin
                dout_next = {rd_byte[3:0], 4'h0};
            end else begin
                dout_next = {rd_byte[7:4], 4'h0};
            end
        end

        if (e_fall) begin
            doe_next = 1'b0;
            if (accept) begin
                if (!bus_width_select && !nib_phase_reg) begin
                    nib_phase_next = 1'b1;
                    nib_hi_next = din_s[7:4];
                end else begin
                    nib_phase_next = 1'b0;
                    if (!rw_s) begin
                        state_next = lcra_pkg::lcra_busy;
                        count_next = INSTR_BUSY_CYCLES - `LCRA_CNT_W'(1);
                        arg_next = full_byte[6:0];
                        dir_next = full_byte[2];
                        if (rs_s) begin
                            op_next = lcra_pkg::lcra_op_write;
                            wdata_next = full_byte;
                            count_next = DATA_BUSY_CYCLES - `LCRA_CNT_W'(1);
                        end else if (full_byte[7]) begin
                            op_next = lcra_pkg::lcra_op_addr_text;
                        end else if (full_byte[6]) begin
                            op_next = lcra_pkg::lcra_op_addr_glyph;
                            arg_next = {1'b0, full_byte[5:0]};
                        end else if (full_byte[5:4] == 2'b01) begin
                            op_next = full_byte[3] ? lcra_pkg::lcra_op_dshift
                                                   : lcra_pkg::lcra_op_cursor;
                        end else begin
                            // other instructions are handled outside this block
                            state_next = lcra_pkg::lcra_idle;
                            op_next = lcra_pkg::lcra_op_none;
                        end
                    end else if (rs_s) begin
                        state_next = lcra_pkg::lcra_busy;
                        op_next = lcra_pkg::lcra_op_read;
                        count_next = DATA_BUSY_CYCLES - `LCRA_CNT_W'(1);
                    end
                end
            end
        end
    end

    // avalon slave: one wait cycle per access, unmapped reads return zero
    always_comb begin
        cfg_next = cfg_reg;
        rdata_next = rdata_reg;
        wait_next = 1'b1;
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
            rdata_next = 32'h0000_0000;
            if (avs_read && avs_address == `LCRA_CFG_OFS) begin
                rdata_next[`LCRA_CFG_W-1:0] = cfg_reg;
            end else if (avs_read && avs_address == `LCRA_STAT_OFS) begin
                rdata_next[`LCRA_STAT_AC_LSB +: 7] = ac_reg;
                rdata_next[`LCRA_STAT_BUSY_BIT] = busy_indicator;
                rdata_next[`LCRA_STAT_GLYPH_BIT] = glyph_sel_reg;
                rdata_next[`LCRA_STAT_SHIFT_LSB +: 7] = shift_reg;
            end
        end
        if (avs_write && !wait_reg && avs_address == `LCRA_CFG_OFS) begin
            cfg_next = avs_writedata[`LCRA_CFG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= lcra_pkg::lcra_idle;
            op_reg <= lcra_pkg::lcra_op_none;
            count_reg <= '0;
            ac_reg <= 7'h00;
            glyph_sel_reg <= 1'b0;
            latch_reg <= 8'h00;
            wdata_reg <= 8'h00;
            arg_reg <= 7'h00;
            dir_reg <= 1'b0;
            nib_hi_reg <= 4'h0;
            nib_phase_reg <= 1'b0;
            e_prev_reg <= 1'b0;
            dout_reg <= 8'h00;
            doe_reg <= 1'b0;
            shift_reg <= 7'h00;
            cfg_reg <= `LCRA_CFG_RESET;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
            op_reg <= op_next;
            count_reg <= count_next;
            ac_reg <= ac_next;
            glyph_sel_reg <= glyph_sel_next;
            latch_reg <= latch_next;
            wdata_reg <= wdata_next;
            arg_reg <= arg_next;
            dir_reg <= dir_next;
            nib_hi_reg <= nib_hi_next;
            nib_phase_reg <= nib_phase_next;
            e_prev_reg <= e_s;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            shift_reg <= shift_next;
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
        end
    end

    // memories carry no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (clk_en && text_we) begin
            text_mem[ac_reg] <= wdata_reg;
        end
        if (clk_en && glyph_we) begin
            glyph_mem[ac_reg[5:0]] <= wdata_reg;
        end
    end

    assign data_out = dout_reg;
    assign data_oe = doe_reg;
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;

endmodule : lcra_core

// *** lcra_checker.sv ***
/*
 * Port-level checker for lcra_core, attached by bind after the module.
 * Assumes one clock domain and sight of the top ports only.
 */
module lcra_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // parallel pins
    input wire logic register_select,
    input wire logic read_not_write,
    input wire logic enable,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    // avalon slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic wide_reg;
    logic wide_next;
    // shadow of the width bit for nibble reads
    always_comb begin
        wide_next = wide_reg;
        if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
            wide_next = avs_writedata[3];
        end
    end
    always_ff @(posedge clk) begin
        wide_reg <= reset ? 1'b1 : wide_next;
    end
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_stat_rise;
        $rose(enable) && read_not_write && !register_select;
    endsequence
    chk_wait_answer: assert property (s_req |=> !avs_waitrequest)
        else $error("waitrequest not low after request");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address != 4'h0 && avs_address != 4'h4 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_drive: assert property (s_stat_rise |-> ##[2:7] data_oe)
        else $error("status read not driven");
    chk_oe_needs_enable: assert property (!enable [*8] |-> !data_oe)
        else $error("bus driven with strobe low");
    chk_write_no_oe: assert property (!read_not_write [*8] |-> !data_oe)
        else $error("bus driven during write");
    chk_read_stands: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
        else $error("read data changed while driven");
    chk_nibble_low: assert property (data_oe && !wide_reg |-> data_out[3:0] == 4'h0)
        else $error("low lines not clear in nibble mode");
endmodule : lcra_checker

bind lcra_core lcra_checker lcra_checker_i (
    .clk(clk), .reset(reset), .register_select(register_select),
    .read_not_write(read_not_write), .enable(enable), .data_out(data_out),
    .data_oe(data_oe), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

// *** lcra_host_model.sv ***
/*
 * Host processor model for the parallel pin port: strobe, select lines, bus.
 * Assumes the bench calls its tasks hierarchically, clocked by the device clock.
 */
module lcra_host_model (
    // clock
    input wire logic clk,
    // device side of the bus
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    // pins the host drives
    output logic register_select,
    output logic read_not_write,
    output logic enable,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] host_d = 8'h00;
    // released bus shows the inverse, not a held copy
    assign data_in = data_oe ? data_out : (read_not_write ? ~host_d : host_d);
    initial begin
        register_select = 1'b0;
        read_not_write = 1'b0;
        enable = 1'b0;
    end
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        register_select <= rs;
        read_not_write <= rw;
        if (!rw) begin
            host_d <= d;
        end
        repeat (2) @(posedge clk);
        enable <= 1'b1;
        repeat (8) @(posedge clk);
        q = data_in; // read taken while strobe high
        enable <= 1'b0; // write taken on this fall
        repeat (8) @(posedge clk);
    endtask : xfer
    task automatic xfer4(input logic rs, input logic rw, input logic [7:0] d,
                         output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        xfer(rs, rw, {d[7:4], 4'h0}, hi); // high nibble first
        xfer(rs, rw, {d[3:0], 4'h0}, lo);
        q = {hi[7:4], lo[7:4]};
    endtask : xfer4
endmodule : lcra_host_model

// *** testbench.sv ***
/*
 * Self-checking bench for lcra_core: host model on the pins, avalon master.
 * Assumes shortened busy counts.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic register_select;
    logic read_not_write;
    logic enable;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic data_oe;
    logic nib = 1'b0;
    logic [7:0] q;
    logic [31:0] w;
    int failures = 0;
    int samples_checked = 0;
    lcra_core #(.INSTR_BUSY_CYCLES(13'h028), .DATA_BUSY_CYCLES(13'h032)) lcra_core_i (
        .clk(clk), .reset(reset), .clk_en(clk_en), .register_select(register_select),
        .read_not_write(read_not_write), .enable(enable), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    lcra_host_model lcra_host_model_i (
        .clk(clk), .data_out(data_out), .data_oe(data_oe),
        .register_select(register_select), .read_not_write(read_not_write),
        .enable(enable), .data_in(data_in));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report;
        $display("compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            final_report();
        end
    endtask : av
    task automatic cfg(input logic [3:0] d);
        logic [31:0] x;
        av(1'b1, 4'h0, {28'h0, d}, x);
        nib = !d[3];
    endtask : cfg
    task automatic pin(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] r);
        if (nib) begin
            lcra_host_model_i.xfer4(rs, rw, d, r);
        end else begin
            lcra_host_model_i.xfer(rs, rw, d, r);
        end
    endtask : pin
    task automatic poll;
        logic [7:0] s;
        for (int i = 0; i < 30; i++) begin
            pin(1'b0, 1'b1, 8'h00, s); // status read, repeated until bit 7 shows idle
            if (s[7] === 1'b0) begin
                return;
            end
        end
        failures++;
        final_report();
    endtask : poll
    task automatic op(input logic rs, input logic [7:0] d);
        logic [7:0] s;
        pin(rs, 1'b0, d, s);
        poll();
    endtask : op
    task automatic rd(output logic [7:0] r);
        pin(1'b1, 1'b1, 8'h00, r);
        poll();
    endtask : rd
    task automatic stat(input logic [6:0] a, input string n);
        logic [7:0] s;
        pin(1'b0, 1'b1, 8'h00, s);
        check(n, {24'h0, s}, {24'h0, 1'b0, a});
    endtask : stat
    task automatic t_reset;
        av(1'b0, 4'h0, 32'h0, w);
        check("cfg reset", w, 32'h9);
        av(1'b0, 4'h4, 32'h0, w);
        check("status reset", w, 32'h0);
        av(1'b1, 4'h8, 32'hffffffff, w);
        av(1'b0, 4'h8, 32'h0, w);
        check("unmapped", w, 32'h0);
        av(1'b0, 4'h0, 32'h0, w);
        check("cfg kept", w, 32'h9);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_write_read;
        op(1'b0, 8'h90);
        pin(1'b1, 1'b0, 8'ha5, q);
        pin(1'b0, 1'b1, 8'h00, q);
        check("busy, old ac", {24'h0, q}, 32'h90);
        poll();
        op(1'b1, 8'h3c);
        op(1'b1, 8'h5a);
        stat(7'h13, "ac after writes");
        op(1'b0, 8'h90);
        op(1'b1, 8'h77);
        rd(q);
        check("stale read", {24'h0, q}, 32'ha5);
        rd(q);
        check("second read", {24'h0, q}, 32'h5a);
        op(1'b0, 8'h90);
        rd(q);
        check("read back", {24'h0, q}, 32'h77);
        stat(7'h11, "ac after read");
        op(1'b1, 8'h99);
        op(1'b0, 8'h10);
        rd(q);
        check("cursor read", {24'h0, q}, 32'h99);
        $display("t_write_read done");
    endtask : t_write_read
    task automatic t_modes;
        cfg(4'h8);
        op(1'b0, 8'h85);
        op(1'b1, 8'h11);
        stat(7'h04, "decrement");
        cfg(4'h9);
        op(1'b0, 8'hcf);
        op(1'b1, 8'h22);
        stat(7'h00, "one-line wrap");
        cfg(4'hd);
        op(1'b0, 8'ha7);
        op(1'b1, 8'h33);
        stat(7'h40, "line one end");
        op(1'b0, 8'he7);
        op(1'b1, 8'h44);
        stat(7'h00, "line two end");
        cfg(4'h9);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_glyph;
        op(1'b0, 8'h7f);
        stat(7'h3f, "glyph ac");
        av(1'b0, 4'h4, 32'h0, w);
        check("glyph select", {31'h0, w[8]}, 32'h1);
        op(1'b1, 8'h55);
        stat(7'h00, "glyph wrap");
        op(1'b0, 8'h7f);
        rd(q);
        check("glyph read", {24'h0, q}, 32'h55);
        $display("t_glyph done");
    endtask : t_glyph
    task automatic t_scroll;
        cfg(4'hb);
        op(1'b0, 8'h80);
        op(1'b1, 8'h66);
        av(1'b0, 4'h4, 32'h0, w);
        check("write scroll", {25'h0, w[22:16]}, 32'h7f);
        rd(q);
        av(1'b0, 4'h4, 32'h0, w);
        check("read no scroll", {25'h0, w[22:16]}, 32'h7f);
        op(1'b0, 8'h1c);
        av(1'b0, 4'h4, 32'h0, w);
        check("display shift", {9'h0, w[22:0]}, 32'h2);
        cfg(4'h9);
        $display("t_scroll done");
    endtask : t_scroll
    task automatic t_busy;
        pin(1'b0, 1'b0, 8'h85, q);
        pin(1'b0, 1'b0, 8'h8a, q);
        poll();
        stat(7'h05, "ignored while busy");
        cfg(4'h1);
        stat(7'h05, "nibble status");
        op(1'b0, 8'h8a);
        stat(7'h0a, "nibble address");
        cfg(4'h9);
        stat(7'h0a, "back to bytes");
        $display("t_busy done");
    endtask : t_busy
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_write_read();
        t_modes();
        t_glyph();
        t_scroll();
        t_busy();
        final_report();
    end
endmodule : testbench
